// ### shared/fess_map.svh
// Command codes, address offsets and timing constants of the erase and suspend sequencer.
`ifndef FESS_MAP_SVH
`define FESS_MAP_SVH

// Command data words.
`define FESS_CMD_SETUP 16'h0080
`define FESS_CMD_SECT_ERASE 16'h0030
`define FESS_CMD_CHIP_ERASE 16'h0010
`define FESS_CMD_ERS_SUSP 16'h00b0
`define FESS_CMD_ERS_RESUME 16'h0030
`define FESS_CMD_PGM_SUSP 16'h0051
`define FESS_CMD_PGM_RESUME 16'h0050

// Word offsets within a sector for the two erase cycles.
`define FESS_OFS_W 12
`define FESS_OFS_SETUP 12'h555
`define FESS_OFS_CONFIRM 12'haaa

// Erased and preprogrammed word patterns.
`define FESS_WORD_ERASED 16'hffff
`define FESS_WORD_ZERO 16'h0000

// Default cycle counts: accept window, each erase phase, one embedded program.
// Suspends act on the edge after their command, well inside any latency limit.
`define FESS_SEA_CYC 2000
`define FESS_PHASE_CYC 8000
`define FESS_PROG_CYC 400

`endif

// ### shared/fess_pkg.sv
// Types shared by the erase and suspend sequencer.
package fess_pkg;

  // Erase engine states.
  typedef enum logic [2:0] {
    FESS_E_IDLE = 3'b000,
    FESS_E_SETUP = 3'b001,
    FESS_E_ACCEPT = 3'b010,
    FESS_E_PREPROG = 3'b011,
    FESS_E_VERIFY = 3'b100,
    FESS_E_ERASE = 3'b101,
    FESS_E_SUSP = 3'b110
  } fess_erase_e;

  // Program engine states.
  typedef enum logic [1:0] {
    FESS_P_IDLE = 2'b00,
    FESS_P_RUN = 2'b01,
    FESS_P_SUSP = 2'b10
  } fess_prog_e;

endpackage

// ### testbench/fess_host_bfm.sv
// Host bus model issuing single command write cycles.
`timescale 1ns/100ps
module fess_host_bfm #(
  parameter int AW = 15
) (
  // Clock.
  input wire logic sys_clk_in,
  // Command write cycle.
  output logic cmd_we_out,
  output logic [AW-1:0] cmd_addr_out,
  output logic [15:0] cmd_data_out
);
  initial begin
    cmd_we_out = 1'b0;
    cmd_addr_out = '0;
    cmd_data_out = '0;
  end

  // One write; released lines are inverted so a stale word never looks valid.
  task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    #1;
    cmd_we_out = 1'b1;
    cmd_addr_out = a;
    cmd_data_out = d;
    @(posedge sys_clk_in);
    #1;
    cmd_we_out = 1'b0;
    cmd_addr_out = ~a;
    cmd_data_out = ~d;
  endtask
endmodule

// ### testbench/fess_sequencer_chk.sv
// Concurrent checks on the ports of the erase and suspend sequencer.
`timescale 1ns/100ps
`include "fess_map.svh"
module fess_sequencer_chk #(
  parameter int NSECT = 8,
  parameter int SECT_PER_BANK = 2
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Command and read requests.
  input wire logic cmd_we_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic rd_en_in,
  input wire logic [$clog2(NSECT)+`FESS_OFS_W-1:0] rd_addr_in,
  // Observed answers.
  input wire logic rd_grant_out,
  input wire logic rd_undef_out,
  input wire logic fill_zero_out,
  input wire logic fill_ones_out,
  input wire logic stat_ready_out,
  input wire logic stat_erase_susp_out,
  input wire logic stat_prog_susp_out,
  input wire logic [NSECT-1:0] stat_sect_erasing_out,
  input wire logic [NSECT-1:0] stat_sect_susp_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Sectors in the bank of the read address, so a busy bank can be spotted.
  logic [NSECT-1:0] bank_sects;
  always_comb begin
    for (int i = 0; i < NSECT; i++) begin
      bank_sects[i] = (i / SECT_PER_BANK) == (int'(rd_addr_in >> `FESS_OFS_W) / SECT_PER_BANK);
    end
  end

  // Suspend flags only move in answer to their own command one or two edges earlier.
  a_esusp_by_cmd: assert property (
    $rose(stat_erase_susp_out) |-> $past(cmd_we_in && cmd_data_in == `FESS_CMD_ERS_SUSP)
      || $past(cmd_we_in && cmd_data_in == `FESS_CMD_ERS_SUSP, 2))
    else $error("erase suspend flag rose without its command");
  a_eres_by_cmd: assert property (
    $fell(stat_erase_susp_out) |-> $past(cmd_we_in && cmd_data_in == `FESS_CMD_ERS_RESUME)
      || $past(cmd_we_in && cmd_data_in == `FESS_CMD_ERS_RESUME, 2))
    else $error("erase suspend flag fell without resume");
  a_psusp_by_cmd: assert property (
    $rose(stat_prog_susp_out) |-> $past(cmd_we_in && cmd_data_in == `FESS_CMD_PGM_SUSP)
      || $past(cmd_we_in && cmd_data_in == `FESS_CMD_PGM_SUSP, 2))
    else $error("program suspend flag rose without its command");
  a_pres_by_cmd: assert property (
    $fell(stat_prog_susp_out) |-> $past(cmd_we_in && cmd_data_in == `FESS_CMD_PGM_RESUME)
      || $past(cmd_we_in && cmd_data_in == `FESS_CMD_PGM_RESUME, 2))
    else $error("program suspend flag fell without resume");
  a_susp_masks: assert property (
    stat_erase_susp_out |-> stat_sect_erasing_out == '0 && stat_sect_susp_out != '0)
    else $error("suspended erase still shows erasing sectors");
  a_ready_no_erase: assert property (
    stat_ready_out |-> stat_sect_erasing_out == '0)
    else $error("ready while sectors erasing");
  a_ones_then_idle: assert property (
    fill_ones_out |-> ##[0:2] stat_ready_out)
    else $error("no return to idle after erase");
  a_zero_busy: assert property (
    fill_zero_out |-> !stat_ready_out)
    else $error("preprogram pulse while idle");
  a_busy_bank: assert property (
    rd_en_in && (stat_sect_erasing_out & bank_sects) != '0 |=> !rd_grant_out)
    else $error("read granted in erasing bank");
  a_grant_cause: assert property (
    rd_grant_out |-> $past(rd_en_in) && !(rd_undef_out && !stat_erase_susp_out))
    else $error("grant without request or undefined read outside suspend");
endmodule

bind fess_sequencer fess_sequencer_chk #(.NSECT(NSECT), .SECT_PER_BANK(SECT_PER_BANK)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cmd_we_in(cmd_we_in),
  .cmd_data_in(cmd_data_in), .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in),
  .rd_grant_out(rd_grant_out), .rd_undef_out(rd_undef_out), .fill_zero_out(fill_zero_out),
  .fill_ones_out(fill_ones_out), .stat_ready_out(stat_ready_out),
  .stat_erase_susp_out(stat_erase_susp_out), .stat_prog_susp_out(stat_prog_susp_out),
  .stat_sect_erasing_out(stat_sect_erasing_out), .stat_sect_susp_out(stat_sect_susp_out)
);

// ### testbench/fess_sequencer_tb.sv
// Self-checking bench for the erase and suspend sequencer.
`timescale 1ns/100ps
`include "fess_map.svh"
module fess_sequencer_tb;
  localparam int AW = 15;
  logic sys_clk_in, rst_n_in, cmd_we_in, prog_start_in, rd_en_in, rd_grant_out, rd_undef_out;
  logic fill_zero_out, fill_ones_out, prog_step_out, stat_ready_out, stat_erase_susp_out;
  logic stat_prog_susp_out;
  logic [AW-1:0] cmd_addr_in, prog_addr_in, rd_addr_in;
  logic [15:0] cmd_data_in;
  logic [7:0] sect_unlocked_in, range_locked_in, fill_mask_out, stat_sect_erasing_out;
  logic [7:0] stat_sect_susp_out;
  int n_fail = 0;
  int samples_checked = 0;

  fess_host_bfm #(.AW(AW)) host (.sys_clk_in(sys_clk_in), .cmd_we_out(cmd_we_in),
    .cmd_addr_out(cmd_addr_in), .cmd_data_out(cmd_data_in));

  // Short counts keep the run small; the order of phases is unchanged.
  fess_sequencer #(.NSECT(8), .SECT_PER_BANK(2), .SEA_CYC(6), .PHASE_CYC(8), .PROG_CYC(40)) dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cmd_we_in(cmd_we_in),
    .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .prog_start_in(prog_start_in),
    .prog_addr_in(prog_addr_in), .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in),
    .sect_unlocked_in(sect_unlocked_in), .range_locked_in(range_locked_in),
    .rd_grant_out(rd_grant_out), .rd_undef_out(rd_undef_out), .fill_zero_out(fill_zero_out),
    .fill_ones_out(fill_ones_out), .prog_step_out(prog_step_out), .fill_mask_out(fill_mask_out),
    .stat_ready_out(stat_ready_out), .stat_erase_susp_out(stat_erase_susp_out),
    .stat_prog_susp_out(stat_prog_susp_out), .stat_sect_erasing_out(stat_sect_erasing_out),
    .stat_sect_susp_out(stat_sect_susp_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic c, input string m);
    samples_checked++;
    if (c !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  // Two-cycle erase sequence: setup in sector a, second cycle at sector b, offset o.
  task automatic ers(input logic [2:0] a, input logic [2:0] b, input logic [11:0] o,
                     input logic [15:0] d);
    host.wr({a, `FESS_OFS_SETUP}, `FESS_CMD_SETUP);
    host.wr({b, o}, d);
  endtask

  // Read request; the grant is answered and sampled one edge later.
  task automatic rd(input logic [AW-1:0] a, input logic g, input logic u);
    @(posedge sys_clk_in);
    #1 rd_en_in = 1'b1;
    rd_addr_in = a;
    @(posedge sys_clk_in);
    #1 rd_en_in = 1'b0;
    rd_addr_in = ~a;
    chk(rd_grant_out === g && rd_undef_out === u, "read gating");
  endtask

  task automatic pgm(input logic [AW-1:0] a);
    @(posedge sys_clk_in);
    #1 prog_start_in = 1'b1;
    prog_addr_in = a;
    @(posedge sys_clk_in);
    #1 prog_start_in = 1'b0;
  endtask

  // Bounded wait for a fill pulse, then its sector mask is compared.
  task automatic wait_fill(input logic ones, input logic [7:0] m);
    int k;
    for (k = 0; k < 300; k++) begin
      cyc(1);
      if ((ones ? fill_ones_out : fill_zero_out) === 1'b1) break;
    end
    chk(k < 300 && fill_mask_out === m, "fill pulse or mask");
    if (k == 300) conclude();
  endtask

  task automatic idle_chk(input string m);
    cyc(1);
    chk(stat_ready_out === 1'b1 && stat_sect_erasing_out === 8'h00, m);
  endtask

  task automatic t_refused();
    range_locked_in = 8'h08;
    ers(3'h3, 3'h3, `FESS_OFS_CONFIRM, `FESS_CMD_SECT_ERASE);
    idle_chk("erase of range locked sector");
    ers(3'h0, 3'h0, `FESS_OFS_CONFIRM, `FESS_CMD_CHIP_ERASE);
    idle_chk("chip erase with range lock");
    range_locked_in = 8'h00;
    sect_unlocked_in = 8'hfe;
    ers(3'h0, 3'h0, `FESS_OFS_CONFIRM, `FESS_CMD_CHIP_ERASE);
    idle_chk("chip erase with sector 0 locked");
    ers(3'h0, 3'h0, `FESS_OFS_CONFIRM, `FESS_CMD_SECT_ERASE);
    idle_chk("erase of locked sector");
    sect_unlocked_in = 8'hff;
    ers(3'h1, 3'h2, `FESS_OFS_CONFIRM, `FESS_CMD_SECT_ERASE);
    idle_chk("erase with differing sectors");
    ers(3'h1, 3'h1, `FESS_OFS_SETUP, `FESS_CMD_SECT_ERASE);
    idle_chk("erase with wrong offset");
    ers(3'h1, 3'h1, `FESS_OFS_CONFIRM, `FESS_CMD_PGM_SUSP);
    idle_chk("erase with wrong data");
  endtask

  task automatic t_sector();
    ers(3'h5, 3'h5, `FESS_OFS_CONFIRM, `FESS_CMD_SECT_ERASE);
    ers(3'h2, 3'h2, `FESS_OFS_CONFIRM, `FESS_CMD_SECT_ERASE);
    cyc(1);
    chk(stat_sect_erasing_out === 8'h24 && stat_ready_out === 1'b0, "erase mask");
    rd({3'h4, 12'h010}, 1'b0, 1'b0);
    rd({3'h0, 12'h010}, 1'b1, 1'b0);
    wait_fill(1'b0, 8'h24);
    host.wr({3'h0, 12'h000}, `FESS_CMD_PGM_SUSP);
    pgm({3'h0, 12'h020});
    cyc(1);
    chk(stat_prog_susp_out === 1'b0 && prog_step_out === 1'b0, "command not ignored");
    wait_fill(1'b1, 8'h24);
    idle_chk("no idle after sector erase");
  endtask

  task automatic t_chip();
    ers(3'h0, 3'h0, `FESS_OFS_CONFIRM, `FESS_CMD_CHIP_ERASE);
    cyc(1);
    chk(stat_ready_out === 1'b0, "chip erase not started");
    rd({3'h7, 12'h123}, 1'b0, 1'b0);
    host.wr({3'h0, 12'h000}, `FESS_CMD_ERS_SUSP);
    cyc(1);
    chk(stat_erase_susp_out === 1'b0, "chip erase suspended");
    wait_fill(1'b1, 8'hff);
    idle_chk("no idle after chip erase");
  endtask

  task automatic t_susp();
    int k;
    ers(3'h6, 3'h6, `FESS_OFS_CONFIRM, `FESS_CMD_SECT_ERASE);
    wait_fill(1'b0, 8'h40);
    host.wr({3'h6, 12'h000}, `FESS_CMD_ERS_SUSP);
    cyc(1);
    chk(stat_erase_susp_out === 1'b1 && stat_sect_susp_out === 8'h40, "erase suspend");
    chk(stat_sect_erasing_out === 8'h00, "suspended sector shown erasing");
    rd({3'h6, 12'h100}, 1'b1, 1'b1);
    rd({3'h7, 12'h100}, 1'b1, 1'b0);
    pgm({3'h1, 12'h020});
    cyc(1);
    chk(prog_step_out === 1'b1, "program refused in erase suspend");
    host.wr({3'h3, 12'h7ff}, `FESS_CMD_PGM_SUSP);
    cyc(1);
    chk(stat_prog_susp_out === 1'b1 && prog_step_out === 1'b0, "program suspend");
    rd({3'h0, 12'h004}, 1'b1, 1'b0);
    rd({3'h1, 12'h020}, 1'b0, 1'b0);
    host.wr({3'h0, 12'h000}, `FESS_CMD_PGM_RESUME);
    cyc(1);
    chk(stat_prog_susp_out === 1'b0 && prog_step_out === 1'b1, "program resume");
    host.wr({3'h0, 12'h000}, `FESS_CMD_PGM_SUSP);
    cyc(1);
    chk(stat_prog_susp_out === 1'b1, "second program suspend");
    host.wr({3'h0, 12'h000}, `FESS_CMD_PGM_RESUME);
    host.wr({3'h0, 12'h000}, `FESS_CMD_PGM_RESUME);
    cyc(1);
    chk(stat_prog_susp_out === 1'b0 && prog_step_out === 1'b1, "repeat resume");
    for (k = 0; k < 100 && prog_step_out === 1'b1; k++) cyc(1);
    chk(k < 100 && stat_erase_susp_out === 1'b1, "program end left erase suspend");
    host.wr({3'h6, 12'h000}, `FESS_CMD_ERS_RESUME);
    host.wr({3'h6, 12'h000}, `FESS_CMD_ERS_RESUME);
    cyc(1);
    chk(stat_erase_susp_out === 1'b0 && stat_sect_erasing_out === 8'h40, "resume");
    host.wr({3'h6, 12'h000}, `FESS_CMD_ERS_SUSP);
    cyc(1);
    chk(stat_erase_susp_out === 1'b1, "second erase suspend");
    host.wr({3'h6, 12'h000}, `FESS_CMD_ERS_RESUME);
    wait_fill(1'b1, 8'h40);
  endtask

  // Reset inside the accept window must abort the erase; a reissued sequence must then run.
  task automatic t_abort();
    ers(3'h3, 3'h3, `FESS_OFS_CONFIRM, `FESS_CMD_SECT_ERASE);
    cyc(3);
    rst_n_in = 1'b0;
    idle_chk("reset did not abort erase");
    rst_n_in = 1'b1;
    ers(3'h3, 3'h3, `FESS_OFS_CONFIRM, `FESS_CMD_SECT_ERASE);
    cyc(1);
    chk(stat_sect_erasing_out === 8'h08, "reissued erase");
    wait_fill(1'b1, 8'h08);
  endtask

  initial begin
    rst_n_in = 1'b0;
    prog_start_in = 1'b0;
    prog_addr_in = '0;
    rd_en_in = 1'b0;
    rd_addr_in = '0;
    sect_unlocked_in = 8'hff;
    range_locked_in = 8'h00;
    cyc(6);
    rst_n_in = 1'b1;
    idle_chk("reset state");
    t_refused();
    t_sector();
    t_chip();
    t_susp();
    t_abort();
    conclude();
  end
endmodule

// ### verilog/fess_sequencer.sv
// Command sequencer for sector erase, chip erase and program/erase suspend and resume.
//
// Summary of operation
// - Program suspend during programming halts it within latency and updates status.
// - Program suspend is one write of 0051h; address is ignored.
// - While program suspended, reads allowed outside suspended program and erase regions.
// - Program resume, one write of 0050h, restarts programming and refreshes status.
// - Only program resume leaves program suspend; extra resumes are ignored.
// - After resuming, a new program suspend is accepted again.
// - Sector erase: 0080h at sector+555h, then 0030h at sector+AAAh.
// - Sector erase starts only if sectors match, offsets right, unlocked, not range locked.
// - Erase preprograms, verifies zeros, then erases sector to FFFFh on its own.
// - More sectors may be added while each command lands inside the accept window.
// - During sector erase only outside-bank reads, status and erase suspend count.
// - Finished sector erase returns bank to idle and drops latched addresses.
// - Hardware reset aborts erase at once; host then reissues the whole sequence.
// - Chip erase: 0080h at base+555h, then 0010h at base+AAAh.
// - Chip erase refused if any sector range locked or sector 0 still locked.
// - Chip erase blocks all array reads and ignores every command.
// - Finished chip erase leaves all words FFFFh and the device idle, unlatched.
// - Erase suspend acts only during sector erase, never during chip erase.
// - Erase suspend stops erase within latency, then reads and programs are allowed.
// - Reads of suspended sectors are undefined; status tells erasing from suspended.
// - Program during erase suspend returns to erase suspend, not idle.
// - Erase resume restarts erase; extra resumes ignored; new suspend accepted.
// - Erase suspend is one write of 00B0h to a bank address.
// - Erase resume is one write of 0030h to a bank address.
`timescale 1ns/100ps
`include "fess_map.svh"

module fess_sequencer
  import fess_pkg::*;
#(
  parameter int NSECT = 8,
  parameter int SECT_PER_BANK = 2,
  parameter int SEA_CYC = `FESS_SEA_CYC,
  parameter int PHASE_CYC = `FESS_PHASE_CYC,
  parameter int PROG_CYC = `FESS_PROG_CYC
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Command write cycles from the host bus.
  input wire logic cmd_we_in,
  input wire logic [$clog2(NSECT)+`FESS_OFS_W-1:0] cmd_addr_in,
  input wire logic [15:0] cmd_data_in,
  // Start of an embedded word or buffer program, from the program loader.
  input wire logic prog_start_in,
  input wire logic [$clog2(NSECT)+`FESS_OFS_W-1:0] prog_addr_in,
  // Array read requests.
  input wire logic rd_en_in,
  input wire logic [$clog2(NSECT)+`FESS_OFS_W-1:0] rd_addr_in,
  // Sector protection state.
  input wire logic [NSECT-1:0] sect_unlocked_in,
  input wire logic [NSECT-1:0] range_locked_in,
  // Read gating answers, one cycle after the request.
  output logic rd_grant_out,
  output logic rd_undef_out,
  // Array operations: one-cycle fill pulses with the sectors they apply to, and a program step held high every cycle a program runs.
  output logic fill_zero_out,
  output logic fill_ones_out,
  output logic prog_step_out,
  output logic [NSECT-1:0] fill_mask_out,
  // Status bits.
  output logic stat_ready_out,
  output logic stat_erase_susp_out,
  output logic stat_prog_susp_out,
  output logic [NSECT-1:0] stat_sect_erasing_out,
  output logic [NSECT-1:0] stat_sect_susp_out
);

  localparam int SECT_W = $clog2(NSECT);
  localparam int AW = SECT_W + `FESS_OFS_W;

  // Elaboration guards: sector indices must cover every sector exactly, counters are 24 bits.
  if (NSECT < 2 || (NSECT & (NSECT - 1)) != 0 || SECT_PER_BANK < 1 ||
      (NSECT % SECT_PER_BANK) != 0) begin : g_bad_geom
    $error("fess_sequencer: bad sector or bank geometry");
  end
  if (SEA_CYC < 1 || PHASE_CYC < 1 || PROG_CYC < 1 || PHASE_CYC >= (1 << 24) ||
      PROG_CYC >= (1 << 24) || SEA_CYC >= (1 << 24)) begin : g_bad_count
    $error("fess_sequencer: counts out of range");
  end

  fess_erase_e ers_st_ff;
  fess_erase_e ers_resume_ff;
  fess_prog_e prg_st_ff;
  logic chip_ff;
  logic add_setup_ff;
  logic [SECT_W-1:0] setup_sect_ff;
  logic [NSECT-1:0] ers_mask_ff;
  logic [SECT_W-1:0] prg_sect_ff;
  logic [23:0] ers_cnt_ff;
  logic [23:0] prg_cnt_ff;
  logic rd_grant_ff;
  logic rd_undef_ff;
  logic fill_zero_ff;
  logic fill_ones_ff;
  logic prog_step_ff;
  logic [NSECT-1:0] fill_mask_ff;

  // Command cycle decode used by the erase engine.
  logic [SECT_W-1:0] cmd_sect;
  logic [`FESS_OFS_W-1:0] cmd_ofs;
  logic is_setup;
  logic is_sect_cfm;
  logic is_chip_cfm;
  logic sect_ok;
  logic chip_ok;
  logic ers_running;
  logic [NSECT-1:0] cmd_onehot;

  assign cmd_sect = cmd_addr_in[AW-1:`FESS_OFS_W];
  assign cmd_ofs = cmd_addr_in[`FESS_OFS_W-1:0];
  assign is_setup = cmd_we_in && cmd_data_in == `FESS_CMD_SETUP &&
                    cmd_ofs == `FESS_OFS_SETUP;
  assign is_sect_cfm = cmd_we_in && cmd_data_in == `FESS_CMD_SECT_ERASE &&
                       cmd_ofs == `FESS_OFS_CONFIRM;
  assign is_chip_cfm = cmd_we_in && cmd_data_in == `FESS_CMD_CHIP_ERASE &&
                       cmd_ofs == `FESS_OFS_CONFIRM;
  assign cmd_onehot = NSECT'(1) << cmd_sect;
  // Same sector in both cycles, unlocked and outside any locked range.
  assign sect_ok = cmd_sect == setup_sect_ff && sect_unlocked_in[cmd_sect] &&
                   !range_locked_in[cmd_sect];
  assign chip_ok = cmd_sect == setup_sect_ff && sect_unlocked_in[0] &&
                   range_locked_in == '0;
  assign ers_running = ers_st_ff == FESS_E_PREPROG || ers_st_ff == FESS_E_VERIFY ||
                       ers_st_ff == FESS_E_ERASE;

  // Erase engine. Reset aborts any erase in flight; nothing is remembered across it.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ers_st_ff <= FESS_E_IDLE;
      ers_resume_ff <= FESS_E_ERASE;
      chip_ff <= 1'b0;
      add_setup_ff <= 1'b0;
      setup_sect_ff <= '0;
      ers_mask_ff <= '0;
      ers_cnt_ff <= '0;
    end else begin
      case (ers_st_ff)
        FESS_E_IDLE: begin
          // A program in flight owns the command port; erase setup is ignored unless the program engine is idle.
          if (is_setup && prg_st_ff == FESS_P_IDLE) begin
            ers_st_ff <= FESS_E_SETUP;
            setup_sect_ff <= cmd_sect;
          end
        end
        FESS_E_SETUP: begin
          if (cmd_we_in) begin
            if (is_sect_cfm && sect_ok) begin
              ers_st_ff <= FESS_E_ACCEPT;
              ers_mask_ff <= cmd_onehot;
              chip_ff <= 1'b0;
              ers_cnt_ff <= '0;
            end else if (is_chip_cfm && chip_ok) begin
              ers_st_ff <= FESS_E_PREPROG;
              ers_mask_ff <= '1;
              chip_ff <= 1'b1;
              ers_cnt_ff <= '0;
            end else begin
              ers_st_ff <= FESS_E_IDLE;
            end
          end
        end
        FESS_E_ACCEPT: begin
          // Each added sector restarts the window, so the list has no fixed limit.
          if (add_setup_ff && cmd_we_in) begin
            add_setup_ff <= 1'b0;
            if (is_sect_cfm && sect_ok) begin
              ers_mask_ff <= ers_mask_ff | cmd_onehot;
              ers_cnt_ff <= '0;
            end else begin
              ers_cnt_ff <= ers_cnt_ff + 24'h000001;
            end
          end else if (is_setup) begin
            add_setup_ff <= 1'b1;
            setup_sect_ff <= cmd_sect;
            ers_cnt_ff <= ers_cnt_ff + 24'h000001;
          end else if (ers_cnt_ff >= 24'(SEA_CYC - 1)) begin
            ers_st_ff <= FESS_E_PREPROG;
            add_setup_ff <= 1'b0;
            ers_cnt_ff <= '0;
          end else begin
            ers_cnt_ff <= ers_cnt_ff + 24'h000001;
          end
        end
        FESS_E_PREPROG, FESS_E_VERIFY, FESS_E_ERASE: begin
          if (!chip_ff && cmd_we_in && cmd_data_in == `FESS_CMD_ERS_SUSP) begin
            ers_resume_ff <= ers_st_ff;
            ers_st_ff <= FESS_E_SUSP;
          end else if (ers_cnt_ff >= 24'(PHASE_CYC - 1)) begin
            ers_cnt_ff <= '0;
            if (ers_st_ff == FESS_E_PREPROG) begin
              ers_st_ff <= FESS_E_VERIFY;
            end else if (ers_st_ff == FESS_E_VERIFY) begin
              ers_st_ff <= FESS_E_ERASE;
            end else begin
              ers_st_ff <= FESS_E_IDLE;
              ers_mask_ff <= '0;
              chip_ff <= 1'b0;
            end
          end else begin
            ers_cnt_ff <= ers_cnt_ff + 24'h000001;
          end
        end
        FESS_E_SUSP: begin
          // The phase count is frozen, so resume carries on where erase stopped.
          if (cmd_we_in && cmd_data_in == `FESS_CMD_ERS_RESUME &&
              prg_st_ff == FESS_P_IDLE) begin
            ers_st_ff <= ers_resume_ff;
          end
        end
        default: ers_st_ff <= FESS_E_IDLE;
      endcase
    end
  end

  // Program engine. Starts from idle or from erase suspend, outside erasing sectors.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prg_st_ff <= FESS_P_IDLE;
      prg_sect_ff <= '0;
      prg_cnt_ff <= '0;
    end else begin
      case (prg_st_ff)
        FESS_P_IDLE: begin
          if (prog_start_in && (ers_st_ff == FESS_E_IDLE ||
              (ers_st_ff == FESS_E_SUSP &&
               !ers_mask_ff[prog_addr_in[AW-1:`FESS_OFS_W]]))) begin
            prg_st_ff <= FESS_P_RUN;
            prg_sect_ff <= prog_addr_in[AW-1:`FESS_OFS_W];
            prg_cnt_ff <= '0;
          end
        end
        FESS_P_RUN: begin
          if (cmd_we_in && cmd_data_in == `FESS_CMD_PGM_SUSP) begin
            prg_st_ff <= FESS_P_SUSP;
          end else if (prg_cnt_ff >= 24'(PROG_CYC - 1)) begin
            prg_st_ff <= FESS_P_IDLE;
          end else begin
            prg_cnt_ff <= prg_cnt_ff + 24'h000001;
          end
        end
        FESS_P_SUSP: begin
          if (cmd_we_in && cmd_data_in == `FESS_CMD_PGM_RESUME) begin
            prg_st_ff <= FESS_P_RUN;
          end
        end
        default: prg_st_ff <= FESS_P_IDLE;
      endcase
    end
  end

  // Read gating, answered on the edge after the request.
  logic [SECT_W-1:0] rd_sect;
  logic [NSECT-1:0] busy_bank_mask;
  logic [NSECT-1:0] prg_bank_mask;
  logic rd_block;

  assign rd_sect = rd_addr_in[AW-1:`FESS_OFS_W];

  // Expand the erasing and programming sectors to whole banks.
  always_comb begin
    busy_bank_mask = '0;
    prg_bank_mask = '0;
    for (int s = 0; s < NSECT; s++) begin
      for (int t = 0; t < NSECT; t++) begin
        if (s / SECT_PER_BANK == t / SECT_PER_BANK) begin
          if (ers_mask_ff[t] && (ers_running || ers_st_ff == FESS_E_ACCEPT))
            busy_bank_mask[s] = 1'b1;
          if (prg_st_ff == FESS_P_RUN && prg_sect_ff == SECT_W'(t))
            prg_bank_mask[s] = 1'b1;
        end
      end
    end
  end

  assign rd_block = (chip_ff && ers_st_ff != FESS_E_IDLE) ||
                    busy_bank_mask[rd_sect] ||
                    prg_bank_mask[rd_sect] ||
                    (prg_st_ff == FESS_P_SUSP && prg_sect_ff == rd_sect);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_grant_ff <= 1'b0;
      rd_undef_ff <= 1'b0;
    end else begin
      rd_grant_ff <= rd_en_in && !rd_block;
      rd_undef_ff <= rd_en_in && !rd_block && ers_st_ff == FESS_E_SUSP &&
                     ers_mask_ff[rd_sect];
    end
  end

  // Array fill pulses at the end of the preprogram and erase phases.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fill_zero_ff <= 1'b0;
      fill_ones_ff <= 1'b0;
      prog_step_ff <= 1'b0;
      fill_mask_ff <= '0;
    end else begin
      // Only an accepted suspend holds the phase back; ignored writes must not drop the pulse.
      fill_zero_ff <= ers_st_ff == FESS_E_PREPROG && ers_cnt_ff >= 24'(PHASE_CYC - 1) &&
                      (chip_ff || !(cmd_we_in && cmd_data_in == `FESS_CMD_ERS_SUSP));
      fill_ones_ff <= ers_st_ff == FESS_E_ERASE && ers_cnt_ff >= 24'(PHASE_CYC - 1) &&
                      (chip_ff || !(cmd_we_in && cmd_data_in == `FESS_CMD_ERS_SUSP));
      prog_step_ff <= prg_st_ff == FESS_P_RUN && !(cmd_we_in &&
                      cmd_data_in == `FESS_CMD_PGM_SUSP);
      fill_mask_ff <= ers_mask_ff;
    end
  end

  // Outputs.
  assign rd_grant_out = rd_grant_ff;
  assign rd_undef_out = rd_undef_ff;
  assign fill_zero_out = fill_zero_ff;
  assign fill_ones_out = fill_ones_ff;
  assign prog_step_out = prog_step_ff;
  assign fill_mask_out = fill_mask_ff;
  assign stat_ready_out = !ers_running && ers_st_ff != FESS_E_ACCEPT &&
                          prg_st_ff != FESS_P_RUN;
  assign stat_erase_susp_out = ers_st_ff == FESS_E_SUSP;
  assign stat_prog_susp_out = prg_st_ff == FESS_P_SUSP;
  assign stat_sect_erasing_out = (ers_running || ers_st_ff == FESS_E_ACCEPT) ?
                                 ers_mask_ff : '0;
  assign stat_sect_susp_out = (ers_st_ff == FESS_E_SUSP) ? ers_mask_ff : '0;

endmodule
